// ==== rtl/filt_cfg_if.sv ====
// configuration and timing signals between the filter control modules
`timescale 1ns/100ps
interface filt_cfg_if;
  import sd_filt_pkg::*;
  logic [6:0]       sf;
  logic [5:0]       af;
  logic             chop;
  logic             ravg;
  logic             restart;
  logic             lp_sel;
  logic [PER_W-1:0] period;
  logic [2:0]       settle;
  logic             conv_strobe;
  logic             result_ready;
  modport top  (output sf, af, chop, ravg, restart, lp_sel,
                input period, settle, conv_strobe, result_ready);
  modport calc (input sf, af, chop, ravg, output period, settle);
  modport gen  (input period, settle, restart, lp_sel, output conv_strobe, result_ready);
endinterface

// ==== rtl/filt_rate_calc.sv ====
// output period and settling count from the filter settings
`timescale 1ns/100ps
module filt_rate_calc
  import sd_filt_pkg::*;
(
  filt_cfg_if.calc cfg
);
  logic [PER_W-1:0] base;
  logic [PER_W-1:0] full;

  always_comb
  begin
    unique case (cfg.sf)
      SF_FORCE_60: base = PERIOD_60HZ;
      SF_FORCE_50: base = PERIOD_50HZ;
      default:     base = (PER_W'(cfg.sf) + PER_W'(1)) << SINC_SHIFT;
    endcase
    full = base;
    if (cfg.chop || (cfg.af != 6'h00))
    begin
      full = PER_W'(base * PER_W'(POST_BASE + int'(cfg.af)));
      if (cfg.af == 6'h00)
      begin
        full = full + PER_W'(CHOP_EXTRA);
      end
    end
    // slowest rate clamp: MAX_PERIOD, the MIN_RATE_HZ rate at MOD_HZ_NORM, well inside the PER_W counter range
    cfg.period = (full > MAX_PERIOD) ? MAX_PERIOD : full;
    if (cfg.chop)
    begin
      cfg.settle = SETTLE_CHOP;
    end
    else if (cfg.af == 6'h00)
    begin
      cfg.settle = cfg.ravg ? SETTLE_PLAIN_RAVG : SETTLE_PLAIN;
    end
    else
    begin
      cfg.settle = cfg.ravg ? SETTLE_AF_RAVG : SETTLE_AF;
    end
  end
endmodule // filt_rate_calc

// ==== rtl/filt_rate_gen.sv ====
// output period timer, settling counter and first-result delay
`timescale 1ns/100ps
module filt_rate_gen
  import sd_filt_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic tick_norm,
  input  wire logic tick_lp,
  filt_cfg_if.gen   cfg
);
  typedef struct packed {
    logic [PER_W-1:0] tick_cnt;
    logic [2:0]       settle_cnt;
    logic [DLY_W-1:0] dly_cnt;
    logic             strobe;
    logic             ready;
  } gen_s;

  localparam gen_s GEN_RST = '{tick_cnt: '0, settle_cnt: 3'h0,
                               dly_cnt: DLY_W'(FIRST_DLY_CYC), strobe: 1'b0, ready: 1'b0};
  gen_s q;
  gen_s d;
  logic tick;

  always_comb
  begin
    tick = cfg.lp_sel ? tick_lp : tick_norm;
    d = q;
    d.strobe = 1'b0;
    d.ready = (q.settle_cnt >= cfg.settle) && (q.dly_cnt == '0);
    if (cfg.restart)
    begin
      d.tick_cnt = '0;
      d.settle_cnt = 3'h0;
      d.dly_cnt = DLY_W'(FIRST_DLY_CYC);
      d.ready = 1'b0;
    end
    else
    begin
      if (q.dly_cnt != '0)
      begin
        d.dly_cnt = q.dly_cnt - DLY_W'(1);
      end
      if (tick)
      begin
        if (q.tick_cnt >= cfg.period - PER_W'(1))
        begin
          d.tick_cnt = '0;
          d.strobe = 1'b1;
          if (q.settle_cnt < cfg.settle)
          begin
            d.settle_cnt = q.settle_cnt + 3'h1;
          end
        end
        else
        begin
          d.tick_cnt = q.tick_cnt + PER_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= GEN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign cfg.conv_strobe = q.strobe;
  assign cfg.result_ready = q.ready;
endmodule // filt_rate_gen

// ==== rtl/sd_filt_ctrl.sv ====
// apb register slave and control of the shared sigma-delta decimation filter
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module sd_filt_ctrl
  import sd_filt_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tick_norm,
  input  wire logic        tick_lp,
  input  wire logic        low_power_mode,
  output logic             adc_reset_i,
  output logic             adc_reset_vt,
  output logic             chop_en,
  output logic             run_avg_en,
  output logic             second_notch_en,
  output logic [6:0]       decimation_factor,
  output logic [5:0]       averaging_factor,
  output logic             filt_clk_lp,
  output logic             result_strobe,
  output logic             result_valid
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0]  xcfg;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic        adc_rst;
    logic        chop;
    logic        ravg;
    logic        notch;
    logic        lp;
    logic        rstrobe;
    logic        rvalid;
  } top_s;

  localparam top_s TOP_RST = '{ctrl: FILTER_CTRL_RST, xcfg: EXT_CFG_RST, rdata: 32'h0,
                               ack: 1'b0, err: 1'b0, adc_rst: 1'b0, chop: 1'b0,
                               ravg: 1'b0, notch: 1'b0, lp: 1'b0, rstrobe: 1'b0,
                               rvalid: 1'b0};

  top_s q;
  top_s d;
  logic setup;
  logic access;
  logic combo_ok;

  filt_cfg_if cfg ();

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    return a == off;
  endfunction

  function automatic logic legal(input logic [6:0] sf, input logic [5:0] af);
    return (sf <= SF_ANY_AF_MAX) || ((sf <= SF_SMALL_AF_MAX) && (af <= AF_SMALL_MAX))
           || (af == 6'h00);
  endfunction

  always_comb
  begin
    setup = psel && !penable;
    access = psel && penable && q.ack;
    combo_ok = legal(q.ctrl[SF_MSB:SF_LSB], q.ctrl[AF_MSB:AF_LSB]);
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.adc_rst = 1'b0;
    // answer is prepared in the setup cycle so pready can come from a flop
    if (setup)
    begin
      d.ack = 1'b1;
      d.err = !(hit(paddr, ADDR_FILTER_CTRL) || hit(paddr, ADDR_EXT_CFG)
                || hit(paddr, ADDR_STATUS));
      d.rdata = 32'h0;
      if (hit(paddr, ADDR_FILTER_CTRL))
      begin
        d.rdata = {16'h0, q.ctrl};
      end
      else if (hit(paddr, ADDR_EXT_CFG))
      begin
        d.rdata = {24'h0, q.xcfg};
      end
      else if (hit(paddr, ADDR_STATUS))
      begin
        d.rdata[ST_READY_BIT] = q.rvalid;
        d.rdata[ST_RAVG_BIT] = q.ravg;
        d.rdata[ST_LP_BIT] = q.lp;
        d.rdata[ST_COMBO_BIT] = !combo_ok;
        d.rdata[ST_PERIOD_LSB +: PER_W] = cfg.period;
      end
    end
    if (access && pwrite)
    begin
      if (hit(paddr, ADDR_FILTER_CTRL))
      begin
        d.ctrl = pwdata[15:0];
        d.adc_rst = pwdata[15:0] != q.ctrl;
      end
      if (hit(paddr, ADDR_EXT_CFG))
      begin
        d.xcfg = pwdata[7:0];
      end
    end
    d.chop = q.ctrl[CHOP_BIT];
    d.ravg = q.ctrl[RAVG_BIT] || q.ctrl[CHOP_BIT];
    d.notch = q.ctrl[NOTCH_BIT];
    d.lp = low_power_mode;
    // result only after settling and delay
    d.rvalid = cfg.result_ready;
    d.rstrobe = cfg.conv_strobe && cfg.result_ready;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= TOP_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign cfg.sf = q.ctrl[SF_MSB:SF_LSB];
  assign cfg.af = q.ctrl[AF_MSB:AF_LSB];
  assign cfg.chop = q.ctrl[CHOP_BIT];
  assign cfg.ravg = q.ctrl[RAVG_BIT] || q.ctrl[CHOP_BIT];
  assign cfg.restart = q.adc_rst;
  assign cfg.lp_sel = q.lp;

  filt_rate_calc u_calc (
    .cfg (cfg.calc)
  );

  filt_rate_gen u_gen (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .tick_norm (tick_norm),
    .tick_lp   (tick_lp),
    .cfg       (cfg.gen)
  );

  assign prdata = q.rdata;
  assign pready = q.ack;
  assign pslverr = q.err;
  assign adc_reset_i = q.adc_rst;
  assign adc_reset_vt = q.adc_rst;
  assign chop_en = q.chop;
  assign run_avg_en = q.ravg;
  assign second_notch_en = q.notch;
  assign decimation_factor = q.ctrl[SF_MSB:SF_LSB];
  assign averaging_factor = q.ctrl[AF_MSB:AF_LSB];
  assign filt_clk_lp = q.lp;
  assign result_strobe = q.rstrobe;
  assign result_valid = q.rvalid;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_ctrl_write;
    psel && penable && pready && pwrite && (paddr == ADDR_FILTER_CTRL);
  endsequence

  sequence s_ctrl_change;
    s_ctrl_write and (pwdata[15:0] != q.ctrl);
  endsequence

  sequence s_ctrl_settled;
    $stable(q.ctrl) [*2];
  endsequence

  property p_reset_on_change;
    s_ctrl_change |=> adc_reset_i && adc_reset_vt ##1 !adc_reset_i;
  endproperty
  a_reset_on_change: assert property (p_reset_on_change)
    else $error("adc reset missing after filter control change");

  property p_no_reset_same;
    s_ctrl_write and (pwdata[15:0] == q.ctrl) |=> !adc_reset_i;
  endproperty
  a_no_reset_same: assert property (p_no_reset_same)
    else $error("adc reset on unchanged filter control write");

  property p_chop_third;
    cfg.chop && (cfg.af == 6'h00) && (cfg.sf < SF_FORCE_60)
      |-> cfg.period == PER_W'((32'(cfg.sf) + 32'h1) * 32'hc0 + 32'h3);
  endproperty
  a_chop_third: assert property (p_chop_third)
    else $error("chop period wrong at zero averaging");

  property p_chop_same_rate;
    cfg.chop && (cfg.af != 6'h00) && (cfg.sf < 7'h08)
      |-> cfg.period == PER_W'((32'(cfg.sf) + 32'h1) * 32'h40 * (32'h3 + 32'(cfg.af)));
  endproperty
  a_chop_same_rate: assert property (p_chop_same_rate)
    else $error("chop changed rate with nonzero averaging");

  property p_chop_settle;
    cfg.chop |-> cfg.settle == 3'h2;
  endproperty
  a_chop_settle: assert property (p_chop_settle)
    else $error("chop settling not two periods");

  property p_ravg_follows;
    s_ctrl_settled |-> run_avg_en == (q.ctrl[RAVG_BIT] || q.ctrl[CHOP_BIT]);
  endproperty
  a_ravg_follows: assert property (p_ravg_follows)
    else $error("running average enable does not follow control");

  property p_ravg_forced;
    q.ctrl[CHOP_BIT] && !q.ctrl[RAVG_BIT] ##1 $stable(q.ctrl) |-> run_avg_en && chop_en;
  endproperty
  a_ravg_forced: assert property (p_ravg_forced)
    else $error("running average not forced by chopping");

  property p_ravg_settle;
    !cfg.chop && cfg.ravg |-> cfg.settle == ((cfg.af == 6'h00) ? 3'h4 : 3'h2);
  endproperty
  a_ravg_settle: assert property (p_ravg_settle)
    else $error("running average settling not one period longer");

  property p_af_rate;
    !cfg.chop && (cfg.af != 6'h00) && (cfg.sf < 7'h08)
      |-> cfg.period == PER_W'((32'(cfg.sf) + 32'h1) * 32'h40 * (32'h3 + 32'(cfg.af)));
  endproperty
  a_af_rate: assert property (p_af_rate)
    else $error("postfilter period wrong");

  property p_notch;
    s_ctrl_settled |-> second_notch_en == q.ctrl[NOTCH_BIT];
  endproperty
  a_notch: assert property (p_notch)
    else $error("second notch enable does not follow control");

  property p_base_rate;
    !cfg.chop && (cfg.af == 6'h00) && (cfg.sf < SF_FORCE_60)
      |-> cfg.period == PER_W'((32'(cfg.sf) + 32'h1) * 32'h40);
  endproperty
  a_base_rate: assert property (p_base_rate)
    else $error("sinc3 base period wrong");

  property p_forced_rate;
    !cfg.chop && (cfg.af == 6'h00) && (cfg.sf >= SF_FORCE_60)
      |-> cfg.period == ((cfg.sf == SF_FORCE_60) ? PERIOD_60HZ : PERIOD_50HZ);
  endproperty
  a_forced_rate: assert property (p_forced_rate)
    else $error("forced mains rate period wrong");

  property p_plain_settle;
    !cfg.chop && !cfg.ravg |-> cfg.settle == ((cfg.af == 6'h00) ? 3'h3 : 3'h1);
  endproperty
  a_plain_settle: assert property (p_plain_settle)
    else $error("settling count wrong without chop");

  property p_first_delay;
    adc_reset_i |-> ##2 !result_valid [*8];
  endproperty
  a_first_delay: assert property (p_first_delay)
    else $error("result valid too soon after adc reset");

  property p_slowest;
    cfg.period <= MAX_PERIOD;
  endproperty
  a_slowest: assert property (p_slowest)
    else $error("output period beyond slowest rate");

  property p_clk_select;
    low_power_mode ##1 low_power_mode |-> filt_clk_lp;
  endproperty
  a_clk_select: assert property (p_clk_select)
    else $error("filter clock not switched to low power oscillator");
endmodule // sd_filt_ctrl

// ==== rtl/sd_filt_pkg.sv ====
// constants shared by the decimation filter control block
package sd_filt_pkg;
  // register map, byte addresses on the apb bus
  localparam logic [31:0] ADDR_FILTER_CTRL = 32'hffff0518;
  localparam logic [31:0] ADDR_EXT_CFG     = 32'hffff051c;
  localparam logic [31:0] ADDR_STATUS      = 32'hffff0520;
  localparam logic [15:0] FILTER_CTRL_RST  = 16'h0007;
  localparam logic [7:0]  EXT_CFG_RST      = 8'h00;
  // filter control fields
  localparam int CHOP_BIT  = 15;
  localparam int RAVG_BIT  = 14;
  localparam int AF_MSB    = 13;
  localparam int AF_LSB    = 8;
  localparam int NOTCH_BIT = 7;
  localparam int SF_MSB    = 6;
  localparam int SF_LSB    = 0;
  // status fields
  localparam int ST_READY_BIT  = 0;
  localparam int ST_RAVG_BIT   = 1;
  localparam int ST_LP_BIT     = 2;
  localparam int ST_COMBO_BIT  = 3;
  localparam int ST_PERIOD_LSB = 12;
  // output period arithmetic, in modulator ticks
  localparam int PER_W       = 20;
  localparam int SINC_SHIFT  = 6;
  localparam int POST_BASE   = 3;
  localparam int CHOP_EXTRA  = 3;
  localparam int MOD_HZ_NORM = 512000;
  localparam int RATE_60_HZ  = 60;
  localparam int RATE_50_HZ  = 50;
  localparam int MIN_RATE_HZ = 4;
  localparam logic [6:0]       SF_FORCE_60 = 7'h7e;
  localparam logic [6:0]       SF_FORCE_50 = 7'h7f;
  localparam logic [PER_W-1:0] PERIOD_60HZ = PER_W'(MOD_HZ_NORM / RATE_60_HZ);
  localparam logic [PER_W-1:0] PERIOD_50HZ = PER_W'(MOD_HZ_NORM / RATE_50_HZ);
  localparam logic [PER_W-1:0] MAX_PERIOD  = PER_W'(MOD_HZ_NORM / MIN_RATE_HZ);
  // permitted factor combinations
  localparam logic [6:0] SF_ANY_AF_MAX   = 7'h1f;
  localparam logic [6:0] SF_SMALL_AF_MAX = 7'h3f;
  localparam logic [5:0] AF_SMALL_MAX    = 6'h07;
  // settling, in output periods
  localparam logic [2:0] SETTLE_CHOP       = 3'h2;
  localparam logic [2:0] SETTLE_PLAIN      = 3'h3;
  localparam logic [2:0] SETTLE_PLAIN_RAVG = 3'h4;
  localparam logic [2:0] SETTLE_AF         = 3'h1;
  localparam logic [2:0] SETTLE_AF_RAVG    = 3'h2;
  // first-result delay on the system clock
  localparam int CLK_HZ        = 25000000;
  localparam int FIRST_DLY_NS  = 60000;
  localparam int FIRST_DLY_CYC = (FIRST_DLY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DLY_W         = 11;
endpackage

// ==== testbench/tb_top.sv ====
// self-checking bench for the decimation filter control block
`timescale 1ns/100ps
module tb_top;
  import sd_filt_pkg::*;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} exp_s;
  logic        clk_sys        = 1'b0;
  logic        rst_b          = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [31:0] paddr          = 32'h0;
  logic [31:0] pwdata         = 32'h0;
  logic        tick_norm      = 1'b0;
  logic        tick_lp        = 1'b0;
  logic        low_power_mode = 1'b0;
  logic [1:0]  tcnt           = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        adc_reset_i;
  logic        adc_reset_vt;
  logic        chop_en;
  logic        run_avg_en;
  logic        second_notch_en;
  logic [6:0]  decimation_factor;
  logic [5:0]  averaging_factor;
  logic        filt_clk_lp;
  logic        result_strobe;
  logic        result_valid;
  int          n_mismatch     = 0;
  int          n_checks       = 0;
  integer      seed           = 50844;
  exp_s        exp_q[$];
  logic        rst_q[$];
  exp_s        mon_e;
  logic [15:0] ctrl_m         = 16'h0007;
  logic        lp_m           = 1'b0;

  sd_filt_ctrl u_dut (
    .clk_sys           (clk_sys),
    .rst_b             (rst_b),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .tick_norm         (tick_norm),
    .tick_lp           (tick_lp),
    .low_power_mode    (low_power_mode),
    .adc_reset_i       (adc_reset_i),
    .adc_reset_vt      (adc_reset_vt),
    .chop_en           (chop_en),
    .run_avg_en        (run_avg_en),
    .second_notch_en   (second_notch_en),
    .decimation_factor (decimation_factor),
    .averaging_factor  (averaging_factor),
    .filt_clk_lp       (filt_clk_lp),
    .result_strobe     (result_strobe),
    .result_valid      (result_valid)
  );

  always #20 clk_sys = ~clk_sys;

  // modulator ticks every second cycle, low-power ticks every fourth
  always @(posedge clk_sys)
  begin
    tcnt      <= tcnt + 2'h1;
    tick_norm <= tcnt[0];
    tick_lp   <= (tcnt == 2'h3);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // the expectation is queued before the request goes out
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    exp_q.push_back(exp_s'{d, m, e});
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctrl(input logic [15:0] c);
    if (c != ctrl_m)
      rst_q.push_back(1'b1);
    ctrl_m = c;
    apb(1'b1, ADDR_FILTER_CTRL, {16'h0, c}, 32'h0, 1'b0);
  endtask

  function automatic logic [31:0] per_of(input logic [15:0] c);
    logic [31:0] b;
    b = (32'(c[6:0]) + 32'h1) * 32'h40;
    if (c[6:0] == 7'h7e)
      b = 32'h2155;
    if (c[6:0] == 7'h7f)
      b = 32'h2800;
    if (c[15] || c[13:8] != 6'h0)
      b = b * (32'h3 + 32'(c[13:8]));
    if (c[15] && c[13:8] == 6'h0)
      b = b + 32'h3;
    if (b > 32'h1f400)
      b = 32'h1f400;
    return b;
  endfunction

  task automatic set_ctrl(input logic [15:0] c);
    logic [31:0] p;
    logic        ill;
    p = per_of(c);
    // combinations outside the permitted table
    ill = (c[6:5] != 2'h0) && (c[13:8] != 6'h0) && (c[6] || (c[13:11] != 3'h0));
    wr_ctrl(c);
    repeat (4) @(posedge clk_sys);
    check(32'(chop_en), 32'(c[15]), "chop");
    check(32'(run_avg_en), 32'(c[14] | c[15]), "running average");
    check(32'(second_notch_en), 32'(c[7]), "second notch");
    check(32'(decimation_factor), 32'(c[6:0]), "decimation");
    check(32'(averaging_factor), 32'(c[13:8]), "averaging");
    apb(1'b0, ADDR_FILTER_CTRL, {16'h0, c}, 32'hffffffff, 1'b0);
    apb(1'b0, ADDR_STATUS, {p[19:0], 8'h0, ill, lp_m, c[14] | c[15], 1'b0},
        32'hfffff00e, 1'b0);
  endtask

  task automatic wait_strobe(output int n);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (result_strobe !== 1'b1 && n < 4000);
  endtask

  // lo: first-valid cycle count, per: strobe spacing in cycles
  task automatic timing(input logic [15:0] c, input int lo, input int per, input logic lp);
    int n;
    @(posedge clk_sys);
    low_power_mode <= lp;
    lp_m = lp;
    wr_ctrl(c);
    repeat (3) @(negedge clk_sys);
    check(32'(result_valid), 32'h0, "valid after restart");
    check(32'(filt_clk_lp), 32'(lp), "filter clock source");
    n = 3;
    while (result_valid !== 1'b1 && n < 5000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n >= lo && n <= lo + 12), 32'h1, "settling time");
    wait_strobe(n);
    wait_strobe(n);
    check(32'(n), 32'(per), "strobe spacing");
    $display("test timing %h done", c);
  endtask

  always @(posedge clk_sys)
  begin
    if (psel && penable && pready === 1'b1)
    begin
      mon_e = exp_q.pop_front();
      check(prdata & mon_e.mask, mon_e.data & mon_e.mask, "read data");
      check(32'(pslverr), 32'(mon_e.err), "slave error");
    end
    if (adc_reset_i === 1'b1 || adc_reset_vt === 1'b1)
    begin
      check(32'(adc_reset_i), 32'(adc_reset_vt), "reset pair");
      if (rst_q.size() == 0)
        check(32'h1, 32'h0, "unexpected adc reset");
      else
        void'(rst_q.pop_front());
    end
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    logic [15:0] fixed [8];
    logic [31:0] r;
    logic [15:0] c;
    fixed = '{16'h007d, 16'h007e, 16'h007f, 16'h807f, 16'h3f1f, 16'h8100, 16'h0100,
              16'h8000};
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(32'(decimation_factor), 32'h7, "reset decimation");
    check(32'(run_avg_en), 32'h0, "reset running average");
    apb(1'b0, ADDR_FILTER_CTRL, 32'h7, 32'hffffffff, 1'b0);
    apb(1'b0, ADDR_EXT_CFG, 32'h0, 32'hffffffff, 1'b0);
    apb(1'b1, ADDR_EXT_CFG, 32'ha5, 32'h0, 1'b0);
    apb(1'b0, ADDR_EXT_CFG, 32'ha5, 32'hffffffff, 1'b0);
    apb(1'b1, 32'hffff0524, 32'h1234, 32'h0, 1'b1);
    apb(1'b0, 32'hffff0524, 32'h0, 32'hffffffff, 1'b1);
    $display("test registers done");
    foreach (fixed[i])
      set_ctrl(fixed[i]);
    // same value again must not reset the adcs
    set_ctrl(fixed[7]);
    set_ctrl(16'h0840);
    $display("test fixed settings done");
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      c = r[15:0];
      case (r[17:16])
        2'h0: c[6:5] = 2'h0;
        2'h1:
        begin
          c[6:5]   = 2'h1;
          c[13:11] = 3'h0;
        end
        default:
        begin
          c[6]    = 1'b1;
          c[13:8] = 6'h0;
        end
      endcase
      set_ctrl(c);
    end
    $display("test random settings done");
    wr_ctrl(16'h0001);
    timing(16'h0000, 1500, 128, 1'b0);
    timing(16'h4003, 2048, 512, 1'b0);
    timing(16'h8000, 1500, 390, 1'b0);
    timing(16'h8100, 1500, 512, 1'b0);
    timing(16'h0000, 1500, 256, 1'b1);
    repeat (5) @(posedge clk_sys);
    check(32'(rst_q.size()), 32'h0, "missing adc reset");
    summarize();
  end
endmodule // tb_top
